// ==== design/lcr_regs.sv ====
// Channel disable, fade configuration, low-dim status and fault flag registers.
`timescale 1ns/1ps
`default_nettype none

module lcr_regs (
    input wire logic clk,
    input wire logic rstn,
    // Register port from the serial interface engine.
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Device context.
    input wire logic global_enable,
    input wire logic dim_cycle_tick,
    input wire logic open_fault_mask,
    input wire logic ground_short_mask,
    input wire logic led_short_mask,
    // Analog detectors and low-dim indicators, asynchronous to clk.
    input wire logic [5:0] low_level_in,
    input wire logic [5:0] open_detect,
    input wire logic [5:0] ground_short_detect,
    input wire logic [5:0] led_short_detect,
    // Controls to the analog and dimming parts.
    output logic pump_off,
    output logic [5:0] sink_on,
    output logic fade_enable,
    output logic [1:0] fade_step,
    output logic fade_update,
    output logic interval_invalid,
    output logic device_shutdown,
    output logic fault_out_n
);
    // =========================================================================
    // Registers written by software
    logic [7:0] sink_off_control;
    logic [7:0] fade_config;
    logic [7:0] next_sink_off_control;
    logic [7:0] next_fade_config;

    wire sel_sink_off = reg_addr == lcr_pkg::ADDR_SINK_OFF;
    wire sel_fade = reg_addr == lcr_pkg::ADDR_FADE;
    wire sel_low_dim = reg_addr == lcr_pkg::ADDR_LOW_DIM;
    wire sel_open = reg_addr == lcr_pkg::ADDR_OPEN;
    wire sel_gnd = reg_addr == lcr_pkg::ADDR_GND_SHORT;
    wire sel_led = reg_addr == lcr_pkg::ADDR_LED_SHORT;

    // Only defined bits are stored, so bits 7 and 6 stay zero.
    assign next_sink_off_control = (reg_wr && sel_sink_off) ?
        (reg_wdata & lcr_pkg::SINK_OFF_WMASK) : sink_off_control;
    assign next_fade_config = (reg_wr && sel_fade) ?
        (reg_wdata & lcr_pkg::FADE_WMASK) : fade_config;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sink_off_control <= lcr_pkg::RST_SINK_OFF;
            fade_config <= lcr_pkg::RST_FADE;
        end else begin
            sink_off_control <= next_sink_off_control;
            fade_config <= next_fade_config;
        end
    end

    // =========================================================================
    // Input synchronisers
    logic [23:0] sync_meta;
    logic [23:0] sync_out;
    wire [23:0] async_in = {led_short_detect, ground_short_detect, open_detect, low_level_in};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync_meta <= 24'h000000;
            sync_out <= 24'h000000;
        end else begin
            sync_meta <= async_in;
            sync_out <= sync_meta;
        end
    end

    wire [5:0] low_level_s = sync_out[5:0];
    wire [5:0] open_s = sync_out[11:6];
    wire [5:0] gnd_s = sync_out[17:12];
    wire [5:0] led_s = sync_out[23:18];

    // =========================================================================
    // Low-dim status register
    logic [5:0] low_dim_status;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            low_dim_status <= lcr_pkg::RST_FLAGS;
        end else begin
            low_dim_status <= low_level_s;
        end
    end

    // =========================================================================
    // Clear-on-read fault flags
    logic [5:0] open_string_flags;
    logic [5:0] ground_short_flags;
    logic [5:0] led_short_flags;

    wire clr_open = reg_rd && sel_open;
    wire clr_gnd = reg_rd && sel_gnd;
    wire clr_led = reg_rd && sel_led;

    lcr_fault_flags u_open (
        .clk(clk),
        .rstn(rstn),
        .detect(open_s),
        .read_clear(clr_open),
        .flags(open_string_flags)
    );

    lcr_fault_flags u_gnd (
        .clk(clk),
        .rstn(rstn),
        .detect(gnd_s),
        .read_clear(clr_gnd),
        .flags(ground_short_flags)
    );

    lcr_fault_flags u_led (
        .clk(clk),
        .rstn(rstn),
        .detect(led_s),
        .read_clear(clr_led),
        .flags(led_short_flags)
    );

    // =========================================================================
    // Read data
    // The value read is the one before the clear, so the host sees every flag it drops;
    // a flag detected again in the clearing cycle stays set and is seen on the next read.
    wire [7:0] read_mux =
        sel_sink_off ? sink_off_control :
        sel_fade ? fade_config :
        sel_low_dim ? {2'h0, low_dim_status} :
        sel_open ? {2'h0, open_string_flags} :
        sel_gnd ? {2'h0, ground_short_flags} :
        sel_led ? {2'h0, led_short_flags} : 8'h00;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= read_mux;
        end
    end

    // =========================================================================
    // Sink and pump controls
    wire pump_bit = sink_off_control[lcr_pkg::PUMP_OFF_BIT];
    wire [4:0] off_bits = sink_off_control[lcr_pkg::SINK_OFF_LSB +: lcr_pkg::NUM_OFF];
    wire pump_cleared = (reg_wr && sel_sink_off) && pump_bit &&
        !reg_wdata[lcr_pkg::PUMP_OFF_BIT];
    logic shutdown_latch;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pump_off <= 1'b0;
            sink_on <= 6'h00;
            shutdown_latch <= 1'b0;
        end else begin
            pump_off <= pump_bit;
            // Channel 1 has no disable bit.
            sink_on <= {~off_bits, 1'b1} & {6{global_enable && !shutdown_latch}};
            // Dropping the pump while running is fatal until reset.
            if (pump_cleared && global_enable) begin
                shutdown_latch <= 1'b1;
            end
        end
    end

    assign device_shutdown = shutdown_latch;

    // =========================================================================
    // Fade configuration and update pacing
    wire [2:0] interval_exp = fade_config[lcr_pkg::INTERVAL_LSB +: lcr_pkg::INTERVAL_W];
    wire interval_bad = interval_exp > lcr_pkg::INTERVAL_MAX;
    wire fade_bit = fade_config[lcr_pkg::FADE_EN_BIT];
    wire gain_bit = fade_config[lcr_pkg::FADE_GAIN_BIT];
    wire [4:0] period_last = 5'((6'h01 << interval_exp) - 6'h01);
    logic [4:0] tick_cnt;
    wire period_done = tick_cnt >= period_last;

    // Unsupported interval codes hold the fade still rather than guess a rate.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tick_cnt <= 5'h00;
            fade_update <= 1'b0;
            fade_enable <= 1'b0;
            fade_step <= lcr_pkg::STEP_SMALL;
            interval_invalid <= 1'b0;
        end else begin
            fade_enable <= fade_bit;
            fade_step <= gain_bit ? lcr_pkg::STEP_LARGE : lcr_pkg::STEP_SMALL;
            interval_invalid <= interval_bad;
            fade_update <= 1'b0;
            if (!fade_bit || interval_bad) begin
                tick_cnt <= 5'h00;
            end else if (dim_cycle_tick) begin
                if (period_done) begin
                    tick_cnt <= 5'h00;
                    fade_update <= 1'b1;
                end else begin
                    tick_cnt <= tick_cnt + 5'h01;
                end
            end
        end
    end

    // =========================================================================
    // Fault output
    wire any_fault = (|open_string_flags && !open_fault_mask) ||
        (|ground_short_flags && !ground_short_mask) ||
        (|led_short_flags && !led_short_mask);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fault_out_n <= 1'b1;
        end else begin
            fault_out_n <= !any_fault;
        end
    end
endmodule // lcr_regs

`default_nettype wire

// ==== design/lcr_pkg.sv ====
// Constants shared by the LED channel control and diagnostic register slice.
package lcr_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int NUM_CH = 6;
    localparam int NUM_OFF = 5;

    // =========================================================================
    // Register offsets
    localparam logic [7:0] ADDR_SINK_OFF = 8'h14;
    localparam logic [7:0] ADDR_FADE = 8'h15;
    localparam logic [7:0] ADDR_LOW_DIM = 8'h16;
    localparam logic [7:0] ADDR_OPEN = 8'h17;
    localparam logic [7:0] ADDR_GND_SHORT = 8'h18;
    localparam logic [7:0] ADDR_LED_SHORT = 8'h19;

    // =========================================================================
    // Reset values
    localparam logic [7:0] RST_SINK_OFF = 8'h00;
    localparam logic [7:0] RST_FADE = 8'h00;
    localparam logic [5:0] RST_FLAGS = 6'h00;

    // =========================================================================
    // Field positions and masks
    localparam int SINK_OFF_LSB = 0;
    localparam int PUMP_OFF_BIT = 5;
    localparam int INTERVAL_LSB = 0;
    localparam int INTERVAL_W = 3;
    localparam int FADE_EN_BIT = 3;
    localparam int FADE_GAIN_BIT = 4;
    localparam logic [7:0] SINK_OFF_WMASK = 8'h3F;
    localparam logic [7:0] FADE_WMASK = 8'h1F;

    // =========================================================================
    // Fade decode
    localparam logic [2:0] INTERVAL_MAX = 3'h5;
    // Fade step expressed in 1/16ths of full scale: 12.5 % and 6.25 %.
    localparam logic [1:0] STEP_LARGE = 2'h2;
    localparam logic [1:0] STEP_SMALL = 2'h1;
    localparam int TICK_CNT_W = 5;
endpackage : lcr_pkg

// ==== design/lcr_fault_flags.sv ====
// Six sticky fault flags that clear when software reads them.
`timescale 1ns/1ps
`default_nettype none

module lcr_fault_flags (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [5:0] detect,
    input wire logic read_clear,
    output logic [5:0] flags
);
    logic [5:0] next_flags;

    // A detection in the clearing cycle is kept, so no event is lost.
    assign next_flags = (flags & ~{6{read_clear}}) | detect;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flags <= lcr_pkg::RST_FLAGS;
        end else begin
            flags <= next_flags;
        end
    end
endmodule // lcr_fault_flags

`default_nettype wire

// ==== verification/lcr_regs_props.sv ====
// Concurrent checks on the ports of the LED channel register slice.
`timescale 1ns/1ps
`default_nettype none
module lcr_regs_props (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic global_enable,
    input wire logic open_fault_mask,
    input wire logic ground_short_mask,
    input wire logic led_short_mask,
    input wire logic pump_off,
    input wire logic [5:0] sink_on,
    input wire logic fade_enable,
    input wire logic [1:0] fade_step,
    input wire logic interval_invalid,
    input wire logic device_shutdown,
    input wire logic fault_out_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire w14 = reg_wr && reg_addr == 8'h14;
    wire w15 = reg_wr && reg_addr == 8'h15;
    AST_PUMP: assert property (w14 |-> ##2 pump_off == $past(reg_wdata[5], 2))
        else $error("pump_off wrong");
    AST_SINK: assert property (w14 && reg_wdata[5] && !device_shutdown ##1 global_enable
        |=> sink_on == {~$past(reg_wdata[4:0], 2), 1'b1}) else $error("sink_on wrong");
    AST_FADE_EN: assert property (w15 |-> ##2 fade_enable == $past(reg_wdata[3], 2))
        else $error("fade_enable wrong");
    AST_STEP: assert property (w15 |-> ##2 fade_step == ($past(reg_wdata[4], 2) ? 2'h2 : 2'h1))
        else $error("fade_step wrong");
    AST_INVALID: assert property (w15 |-> ##2 interval_invalid == ($past(reg_wdata[2:0], 2) > 3'h5))
        else $error("interval_invalid wrong");
    AST_RD_UNMAPPED: assert property (reg_rd && (reg_addr < 8'h14 || reg_addr > 8'h19)
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    AST_RD_TOP: assert property (reg_rd |=> reg_rdata[7:6] == 2'h0)
        else $error("read bits 7:6 not zero");
    AST_MASKED: assert property (open_fault_mask && ground_short_mask && led_short_mask
        |=> fault_out_n) else $error("masked fault drives output");
    AST_SHUT: assert property (device_shutdown |=> device_shutdown && sink_on == 6'h00)
        else $error("shutdown not held");
    cover property (w15 ##2 interval_invalid);
    cover property (device_shutdown);
    cover property (!fault_out_n);
endmodule // lcr_regs_props
bind lcr_regs lcr_regs_props u_chk (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .global_enable(global_enable), .open_fault_mask(open_fault_mask),
    .ground_short_mask(ground_short_mask), .led_short_mask(led_short_mask),
    .pump_off(pump_off), .sink_on(sink_on), .fade_enable(fade_enable), .fade_step(fade_step),
    .interval_invalid(interval_invalid), .device_shutdown(device_shutdown),
    .fault_out_n(fault_out_n));
`default_nettype wire

// ==== verification/lcr_host_model.sv ====
// Host-side model issuing single register reads and writes.
`timescale 1ns/1ps
`default_nettype none
module lcr_host_model (
    input wire logic clk,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // Idle address and data are inverted so nothing can lean on a held value.
    task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = !w;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
        q = reg_rdata;
    endtask
endmodule // lcr_host_model
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench for the LED channel register slice.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, rstn, ge, tick, upd, pump, fen, inv, shut, fault_n, wr, rd;
    logic [2:0] msk;
    logic [5:0] lo, sink;
    logic [1:0] step;
    logic [17:0] det;
    logic [7:0] addr, wdata, rdata, q, v, sv;
    logic [7:0] cfg[$] = '{8'h08, 8'h09, 8'h0B, 8'h0E, 8'h00};
    int npulse[$] = '{8, 4, 1, 0, 0};
    int err_total = 0;
    int total_checks = 0;
    int pulses = 0;
    bit [31:0] seed = 44383;
    lcr_regs i_lcr_regs (.clk(clk), .rstn(rstn), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .global_enable(ge), .dim_cycle_tick(tick),
        .open_fault_mask(msk[0]), .ground_short_mask(msk[1]), .led_short_mask(msk[2]),
        .low_level_in(lo), .open_detect(det[5:0]), .ground_short_detect(det[11:6]),
        .led_short_detect(det[17:12]), .pump_off(pump), .sink_on(sink), .fade_enable(fen),
        .fade_step(step), .fade_update(upd), .interval_invalid(inv),
        .device_shutdown(shut), .fault_out_n(fault_n));
    lcr_host_model host (.clk(clk), .reg_rdata(rdata), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd));
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task automatic chk(input logic [7:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("errors=%0d checks=%0d", err_total, total_checks);
        if (err_total == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic w(input logic [7:0] a, d);
        host.acc(1'b1, a, d, q);
    endtask
    task automatic rc(input logic [7:0] a, e);
        host.acc(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask
    always @(posedge clk) if (upd === 1'b1) pulses <= pulses + 1;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        err_total++;
        summarize();
    end
    initial begin
        {ge, tick, msk, lo, det} = '0;
        rstn = 1'b0;
        cyc(3);
        rstn = 1'b1;
        chk({6'h00, step}, 8'h01);
        chk({7'h00, fault_n}, 8'h01);
        for (int i = 0; i < 6; i++) rc(8'h14 + 8'(i), 8'h00);
        sv = rnd() & 8'hDF | 8'h20;
        w(8'h14, sv);
        rc(8'h14, sv & 8'h3F);
        chk({7'h00, pump}, 8'h01);
        ge = 1'b1;
        cyc(2);
        chk({2'h0, sink}, {2'h0, ~sv[4:0], 1'b1});
        w(8'h16, 8'hFF);
        w(8'h1F, 8'hFF);
        rc(8'h1F, 8'h00);
        lo = 6'(rnd());
        cyc(4);
        rc(8'h16, {2'h0, lo});
        for (int c = 0; c < 8; c++) begin
            v = rnd() & 8'hF8 | 8'(c);
            w(8'h15, v);
            rc(8'h15, v & 8'h1F);
            chk({7'h00, fen}, {7'h00, v[3]});
            chk({6'h00, step}, v[4] ? 8'h02 : 8'h01);
            chk({7'h00, inv}, {7'h00, c > 5});
        end
        foreach (cfg[j]) begin
            w(8'h15, cfg[j]);
            pulses = 0;
            repeat (8) begin
                tick = 1'b1;
                cyc(1);
                tick = 1'b0;
                cyc(2);
            end
            chk(8'(pulses), 8'(npulse[j]));
        end
        for (int k = 0; k < 3; k++) begin
            v = rnd() & 8'h3F | 8'h01;
            det[6*k +: 6] = v[5:0];
            cyc(5);
            chk({7'h00, fault_n}, 8'h00);
            msk[k] = 1'b1;
            cyc(2);
            chk({7'h00, fault_n}, 8'h01);
            msk[k] = 1'b0;
            rc(8'h17 + 8'(k), v);
            det[6*k +: 6] = 6'h00;
            cyc(3);
            rc(8'h17 + 8'(k), v);
            rc(8'h17 + 8'(k), 8'h00);
            // A one-cycle detection leaves the synchroniser exactly at the next read edge.
            det[6*k +: 6] = v[5:0];
            cyc(1);
            det[6*k +: 6] = 6'h00;
            rc(8'h17 + 8'(k), 8'h00);
            rc(8'h17 + 8'(k), v);
            rc(8'h17 + 8'(k), 8'h00);
        end
        msk = 3'h7;
        det = '1;
        cyc(5);
        chk({7'h00, fault_n}, 8'h01);
        msk = 3'h0;
        cyc(2);
        chk({7'h00, fault_n}, 8'h00);
        // Sink bits keep their value after enable; only the pump bit is dropped.
        w(8'h14, sv);
        w(8'h14, sv & 8'hDF);
        cyc(2);
        chk({7'h00, shut}, 8'h01);
        chk({2'h0, sink}, 8'h00);
        summarize();
    end
endmodule // tb
`default_nettype wire
